// [pac_cfg.svh]
// Constants for the autoclass measurement and classification result block
// Notes on behaviour
// - Clear events return class fields to unknown
// - Probe refreshes probe fields, sets probe flag
// - Power-on refreshes assigned field; success sets valid flag
// - Failure-only codes need failure; failure flag set
// - Manual bit write 1 starts measurement
// - Manual bit self-clears when result ready
// - Low nibble enables automatic measurement per port
// - PD request during power-on sets detected flag
// - Auto measure after power-good writes threshold
// - Manual measurement leaves threshold untouched
// - Result registers read-only, bit7 zero, half-watt steps
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PAC_ADDR_CONTROL    8'h50
`define PAC_ADDR_POWER_P1   8'h51
`define PAC_ADDR_POWER_P2   8'h52
`define PAC_ADDR_POWER_P3   8'h53
`define PAC_ADDR_POWER_P4   8'h54
`define PAC_RESET_CONTROL   8'h00
`define PAC_RESET_POWER     7'h00
`define PAC_READ_UNMAPPED   8'h00

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define PAC_MANUAL_LSB      4
`define PAC_AUTO_LSB        0

// ----------------------------------------------------------------------
// Codes and margins
// ----------------------------------------------------------------------
`define PAC_CLASS_UNKNOWN   4'h0
`define PAC_FAIL_ONLY_MASK  16'h8080
`define PAC_THRESH_MARGIN   8'h04

`endif

// [pac_pkg.sv]
// Types shared by the autoclass measurement block
package pac_pkg;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       strobe;
    logic       fail;
    logic [3:0] code;
  } pac_class_evt_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] power;
  } pac_meas_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] value;
  } pac_thresh_t;

  // ----------------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAC_IDLE,
    PAC_MEAS_AUTO,
    PAC_MEAS_MANUAL
  } pac_state_t;

endpackage : pac_pkg

// [pac_meas_port.sv]
// Per-port power measurement sequencer
`include "pac_cfg.svh"

module pac_meas_port (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Control
  input  wire logic                auto_enable,
  input  wire logic                manual_set,
  input  wire logic                power_on_push,
  input  wire logic                power_good,
  input  wire logic                disarm,
  // Measurement engine
  output logic                     meas_req,
  input  wire pac_pkg::pac_meas_t  meas_result,
  // Results
  output logic                     manual_request,
  output logic [6:0]               measured_pd_power,
  output pac_pkg::pac_thresh_t     threshold
);

  pac_pkg::pac_state_t  state;
  pac_pkg::pac_state_t  next_state;
  logic                 armed;
  logic                 next_armed;
  logic                 next_manual_request;
  logic [6:0]           next_measured_pd_power;
  pac_pkg::pac_thresh_t next_threshold;
  logic                 done;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  assign meas_req = (state != pac_pkg::PAC_IDLE);
  assign done     = meas_req && meas_result.valid;

  always_comb
  begin
    next_state             = state;
    next_armed             = armed;
    next_measured_pd_power = measured_pd_power;
    next_threshold         = '0;
    // Enable is sampled only at the push; later edits wait for the next one
    if (power_on_push)
      next_armed = auto_enable;
    else if (disarm)
      next_armed = 1'b0;
    // Set wins over self-clear; a zero write never reaches here
    next_manual_request = manual_set | (manual_request & ~(done && state == pac_pkg::PAC_MEAS_MANUAL));
    case (state)
      pac_pkg::PAC_IDLE:
      begin
        if (armed && power_good && !power_on_push)
        begin
          next_state = pac_pkg::PAC_MEAS_AUTO;
          next_armed = 1'b0;
        end
        else if (manual_request)
          next_state = pac_pkg::PAC_MEAS_MANUAL;
      end
      pac_pkg::PAC_MEAS_AUTO:
      begin
        if (done)
        begin
          next_state             = pac_pkg::PAC_IDLE;
          next_measured_pd_power = meas_result.power;
          next_threshold.wr      = 1'b1;
          next_threshold.value   = {1'b0, meas_result.power} + `PAC_THRESH_MARGIN;
        end
      end
      pac_pkg::PAC_MEAS_MANUAL:
      begin
        // Threshold stays untouched; software owns it after a manual run
        if (done)
        begin
          next_state             = pac_pkg::PAC_IDLE;
          next_measured_pd_power = meas_result.power;
        end
      end
      default:
        next_state = pac_pkg::PAC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state             <= pac_pkg::PAC_IDLE;
      armed             <= 1'b0;
      manual_request    <= 1'b0;
      measured_pd_power <= `PAC_RESET_POWER;
      threshold         <= '0;
    end
    else
    begin
      state             <= next_state;
      armed             <= next_armed;
      manual_request    <= next_manual_request;
      measured_pd_power <= next_measured_pd_power;
      threshold         <= next_threshold;
    end
  end

endmodule : pac_meas_port

// [pac_top.sv]
// Autoclass control, measured power results and classification result fields
`include "pac_cfg.svh"

module pac_top (
  // Clock and reset
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST_B,
  // Register access port
  input  wire logic [7:0]                       REG_ADDR,
  input  wire logic                             REG_WR,
  input  wire logic [7:0]                       REG_WDATA,
  input  wire logic                             REG_RD,
  output logic      [7:0]                       REG_RDATA,
  // Port control events
  input  wire logic [3:0]                       PORT_POWER_ON_PUSH,
  input  wire logic [3:0]                       PORT_POWER_OFF_PUSH,
  input  wire logic [3:0]                       SINGLE_PORT_RESET,
  input  wire logic [3:0]                       PORT_SHUTDOWN_MODE,
  input  wire logic                             GROUP_RESET,
  input  wire logic                             EMERGENCY_SHUTDOWN_PIN,
  // Port status from power stage
  input  wire logic [3:0]                       PORT_POWER_GOOD,
  input  wire logic [3:0]                       PD_REQUEST_SEEN,
  // Classification engine
  input  wire pac_pkg::pac_class_evt_t [3:0]    PROBE_EVT,
  input  wire pac_pkg::pac_class_evt_t [3:0]    POWER_ON_EVT,
  // Measurement engine
  output logic      [3:0]                       MEAS_REQ,
  input  wire pac_pkg::pac_meas_t [3:0]         MEAS_RESULT,
  // Threshold update toward policing
  output pac_pkg::pac_thresh_t [3:0]            POWER_LIMIT_THRESHOLD,
  // Classification results
  output logic      [3:0][3:0]                  PROBE_CLASS,
  output logic      [3:0][3:0]                  REQUESTED_CLASS,
  output logic      [3:0][3:0]                  ASSIGNED_CLASS,
  // Status flags
  output logic      [3:0]                       CLASS_PROBE_COMPLETE,
  output logic      [3:0]                       PORT_POWER_VALID,
  output logic      [3:0]                       POWER_ON_FAILURE,
  output logic      [3:0]                       PD_REQUEST_DETECTED
);

  // ----------------------------------------------------------------------
  // Emergency shutdown pin synchroniser
  // ----------------------------------------------------------------------
  logic esd_ff1;
  logic esd_ff2;
  logic esd_ff3;
  logic esd_level;
  logic esd_evt;
  logic next_esd_level;
  logic next_esd_evt;

  always_comb
  begin
    // Level moves only once the last two stages agree
    next_esd_level = (esd_ff2 == esd_ff3) ? esd_ff3 : esd_level;
    next_esd_evt   = next_esd_level & ~esd_level;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      esd_ff1   <= 1'b0;
      esd_ff2   <= 1'b0;
      esd_ff3   <= 1'b0;
      esd_level <= 1'b0;
      esd_evt   <= 1'b0;
    end
    else
    begin
      esd_ff1   <= EMERGENCY_SHUTDOWN_PIN;
      esd_ff2   <= esd_ff1;
      esd_ff3   <= esd_ff2;
      esd_level <= next_esd_level;
      esd_evt   <= next_esd_evt;
    end
  end

  // ----------------------------------------------------------------------
  // Clear events
  // ----------------------------------------------------------------------
  logic [3:0] clear_evt;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      clear_evt[i] = PORT_SHUTDOWN_MODE[i] | PORT_POWER_OFF_PUSH[i] | SINGLE_PORT_RESET[i]
                     | esd_evt | GROUP_RESET;
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [3:0] automatic_measure_enable;
  logic [3:0] next_automatic_measure_enable;
  logic [3:0] manual_set;
  logic [3:0] manual_measure_request;
  logic       ctrl_wr;

  assign ctrl_wr = REG_WR && (REG_ADDR == `PAC_ADDR_CONTROL);

  always_comb
  begin
    next_automatic_measure_enable = automatic_measure_enable;
    manual_set                    = 4'h0;
    if (ctrl_wr)
    begin
      next_automatic_measure_enable = REG_WDATA[`PAC_AUTO_LSB +: 4];
      // Only ones start a run; zeros are ignored
      manual_set                    = REG_WDATA[`PAC_MANUAL_LSB +: 4];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      automatic_measure_enable <= 4'(`PAC_RESET_CONTROL);
    else
      automatic_measure_enable <= next_automatic_measure_enable;
  end

  // ----------------------------------------------------------------------
  // Measurement sequencers
  // ----------------------------------------------------------------------
  logic [3:0][6:0] measured_pd_power;

  for (genvar p = 0; p < 4; p++)
  begin : g_port
    pac_meas_port u_meas (
      .clk               (CLK_SYS),
      .rst_b             (RST_B),
      .auto_enable       (automatic_measure_enable[p]),
      .manual_set        (manual_set[p]),
      .power_on_push     (PORT_POWER_ON_PUSH[p]),
      .power_good        (PORT_POWER_GOOD[p]),
      .disarm            (clear_evt[p]),
      .meas_req          (MEAS_REQ[p]),
      .meas_result       (MEAS_RESULT[p]),
      .manual_request    (manual_measure_request[p]),
      .measured_pd_power (measured_pd_power[p]),
      .threshold         (POWER_LIMIT_THRESHOLD[p])
    );
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  logic [7:0] next_reg_rdata;

  always_comb
  begin
    next_reg_rdata = REG_RDATA;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `PAC_ADDR_CONTROL:  next_reg_rdata = {manual_measure_request, automatic_measure_enable};
        `PAC_ADDR_POWER_P1: next_reg_rdata = {1'b0, measured_pd_power[0]};
        `PAC_ADDR_POWER_P2: next_reg_rdata = {1'b0, measured_pd_power[1]};
        `PAC_ADDR_POWER_P3: next_reg_rdata = {1'b0, measured_pd_power[2]};
        `PAC_ADDR_POWER_P4: next_reg_rdata = {1'b0, measured_pd_power[3]};
        default:            next_reg_rdata = `PAC_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      REG_RDATA <= `PAC_READ_UNMAPPED;
    else
      REG_RDATA <= next_reg_rdata;
  end

  // ----------------------------------------------------------------------
  // Classification result fields and flags
  // ----------------------------------------------------------------------
  logic [15:0]     fail_only;
  logic [3:0]      power_on_window;
  logic [3:0]      next_power_on_window;
  logic [3:0][3:0] next_probe_class;
  logic [3:0][3:0] next_requested_class;
  logic [3:0][3:0] next_assigned_class;
  logic [3:0]      next_class_probe_complete;
  logic [3:0]      next_port_power_valid;
  logic [3:0]      next_power_on_failure;
  logic [3:0]      next_pd_request_detected;

  assign fail_only = `PAC_FAIL_ONLY_MASK;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      next_probe_class[i]          = PROBE_CLASS[i];
      next_requested_class[i]      = REQUESTED_CLASS[i];
      next_assigned_class[i]       = ASSIGNED_CLASS[i];
      next_class_probe_complete[i] = CLASS_PROBE_COMPLETE[i];
      next_port_power_valid[i]     = PORT_POWER_VALID[i];
      next_power_on_failure[i]     = POWER_ON_FAILURE[i];
      next_pd_request_detected[i]  = PD_REQUEST_DETECTED[i];
      next_power_on_window[i]      = power_on_window[i];
      // Clear first so a same-cycle update survives it
      if (clear_evt[i])
      begin
        next_probe_class[i]          = `PAC_CLASS_UNKNOWN;
        next_requested_class[i]      = `PAC_CLASS_UNKNOWN;
        next_assigned_class[i]       = `PAC_CLASS_UNKNOWN;
        next_class_probe_complete[i] = 1'b0;
        next_port_power_valid[i]     = 1'b0;
        next_power_on_failure[i]     = 1'b0;
        next_pd_request_detected[i]  = 1'b0;
        next_power_on_window[i]      = 1'b0;
      end
      if (PROBE_EVT[i].strobe)
      begin
        next_probe_class[i]          = PROBE_EVT[i].code;
        next_class_probe_complete[i] = 1'b1;
      end
      if (PORT_POWER_ON_PUSH[i])
      begin
        // Requested class is the latest probe result at push time
        next_requested_class[i] = next_probe_class[i];
        next_power_on_window[i] = 1'b1;
      end
      if (power_on_window[i] && PD_REQUEST_SEEN[i])
        next_pd_request_detected[i] = 1'b1;
      if (POWER_ON_EVT[i].strobe && power_on_window[i])
      begin
        next_power_on_window[i] = 1'b0;
        if (POWER_ON_EVT[i].fail)
        begin
          next_assigned_class[i]   = POWER_ON_EVT[i].code;
          next_power_on_failure[i] = 1'b1;
        end
        else
        begin
          // Fault codes are masked so success never reports them
          next_assigned_class[i]   = fail_only[POWER_ON_EVT[i].code] ?
                                     `PAC_CLASS_UNKNOWN : POWER_ON_EVT[i].code;
          next_port_power_valid[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PROBE_CLASS          <= {4{`PAC_CLASS_UNKNOWN}};
      REQUESTED_CLASS      <= {4{`PAC_CLASS_UNKNOWN}};
      ASSIGNED_CLASS       <= {4{`PAC_CLASS_UNKNOWN}};
      CLASS_PROBE_COMPLETE <= 4'h0;
      PORT_POWER_VALID     <= 4'h0;
      POWER_ON_FAILURE     <= 4'h0;
      PD_REQUEST_DETECTED  <= 4'h0;
      power_on_window      <= 4'h0;
    end
    else
    begin
      PROBE_CLASS          <= next_probe_class;
      REQUESTED_CLASS      <= next_requested_class;
      ASSIGNED_CLASS       <= next_assigned_class;
      CLASS_PROBE_COMPLETE <= next_class_probe_complete;
      PORT_POWER_VALID     <= next_port_power_valid;
      POWER_ON_FAILURE     <= next_power_on_failure;
      PD_REQUEST_DETECTED  <= next_pd_request_detected;
      power_on_window      <= next_power_on_window;
    end
  end

endmodule : pac_top

// [pac_top_monitor.sv]
// Port checker for the autoclass measurement block
module pac_top_monitor (
  // Clock and reset
  input wire logic                          CLK_SYS,
  input wire logic                          RST_B,
  // Register port
  input wire logic [7:0]                    REG_ADDR,
  input wire logic                          REG_WR,
  input wire logic [7:0]                    REG_WDATA,
  input wire logic                          REG_RD,
  input wire logic [7:0]                    REG_RDATA,
  // Events
  input wire logic [3:0]                    PORT_POWER_ON_PUSH,
  input wire logic [3:0]                    PORT_POWER_OFF_PUSH,
  input wire logic [3:0]                    SINGLE_PORT_RESET,
  input wire logic [3:0]                    PORT_SHUTDOWN_MODE,
  input wire logic                          GROUP_RESET,
  input wire pac_pkg::pac_class_evt_t [3:0] PROBE_EVT,
  input wire pac_pkg::pac_class_evt_t [3:0] POWER_ON_EVT,
  // Measurement
  input wire logic [3:0]                    MEAS_REQ,
  input wire pac_pkg::pac_meas_t [3:0]      MEAS_RESULT,
  input wire pac_pkg::pac_thresh_t [3:0]    POWER_LIMIT_THRESHOLD,
  // Results
  input wire logic [3:0][3:0]               PROBE_CLASS,
  input wire logic [3:0][3:0]               REQUESTED_CLASS,
  input wire logic [3:0][3:0]               ASSIGNED_CLASS,
  input wire logic [3:0]                    CLASS_PROBE_COMPLETE,
  input wire logic [3:0]                    POWER_ON_FAILURE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);

  // Same-cycle setters win over a clear, so only quiet cycles are judged
  logic clr1;
  logic quiet1;
  assign clr1 = PORT_POWER_OFF_PUSH[1] | SINGLE_PORT_RESET[1] | PORT_SHUTDOWN_MODE[1] | GROUP_RESET;
  assign quiet1 = !PROBE_EVT[1].strobe && !POWER_ON_EVT[1].strobe && !PORT_POWER_ON_PUSH[1];

  sequence s_manual_wr;
    REG_WR && REG_ADDR == 8'h50 && REG_WDATA[4] && !MEAS_REQ[0];
  endsequence
  sequence s_run_end;
    MEAS_REQ[0] && MEAS_RESULT[0].valid;
  endsequence

  property p_manual_start;
    s_manual_wr |=> ##1 MEAS_REQ[0];
  endproperty
  a_manual_start: assert property (p_manual_start) else $error("manual run not started");
  property p_run_hold;
    MEAS_REQ[0] && !MEAS_RESULT[0].valid |=> MEAS_REQ[0];
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run dropped early");
  property p_run_end;
    s_run_end |=> !MEAS_REQ[0];
  endproperty
  a_run_end: assert property (p_run_end) else $error("run did not end");
  property p_thresh;
    POWER_LIMIT_THRESHOLD[0].wr |-> $past(MEAS_RESULT[0].valid) &&
      POWER_LIMIT_THRESHOLD[0].value == {1'b0, $past(MEAS_RESULT[0].power)} + 8'h04;
  endproperty
  a_thresh: assert property (p_thresh) else $error("bad threshold");
  property p_clear;
    clr1 && quiet1 |=> PROBE_CLASS[1] == 4'h0 && REQUESTED_CLASS[1] == 4'h0 &&
      ASSIGNED_CLASS[1] == 4'h0 && !CLASS_PROBE_COMPLETE[1] && !POWER_ON_FAILURE[1];
  endproperty
  a_clear: assert property (p_clear) else $error("fields not cleared");
  property p_probe;
    PROBE_EVT[1].strobe |=> PROBE_CLASS[1] == $past(PROBE_EVT[1].code) && CLASS_PROBE_COMPLETE[1];
  endproperty
  a_probe: assert property (p_probe) else $error("probe result lost");
  property p_fail_code;
    ASSIGNED_CLASS[1] == 4'h7 || ASSIGNED_CLASS[1] == 4'hF |-> POWER_ON_FAILURE[1];
  endproperty
  a_fail_code: assert property (p_fail_code) else $error("fail code without flag");
  property p_rd_bit7;
    REG_RD && REG_ADDR inside {[8'h51:8'h54]} |=> !REG_RDATA[7];
  endproperty
  a_rd_bit7: assert property (p_rd_bit7) else $error("result bit7 set");
  property p_rd_unmapped;
    REG_RD && REG_ADDR > 8'h54 |=> REG_RDATA == 8'h00 ##1 $stable(REG_RDATA) || REG_RD;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule : pac_top_monitor

// [pac_host.sv]
// Host model driving the register port
module pac_host (
  // Clock
  input  wire logic       CLK_SYS,
  // Register port
  output logic      [7:0] REG_ADDR,
  output logic            REG_WR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_WDATA = 8'h00;
    REG_RD = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(negedge CLK_SYS);
    d = REG_RDATA;
  endtask : rd
  // Self-clearing request bit is the only ready indication
  task automatic poll(input int p, output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++)
    begin
      rd(8'h50, v);
      ok = !v[4 + p];
    end
  endtask : poll
endmodule : pac_host

// [pac_top_tb_top.sv]
// Self-checking testbench for the autoclass measurement block
module pac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                          clk_sys = 1'b0;
  logic                          rst_b = 1'b0;
  logic [7:0]                    addr, wdata, rdata, rdv;
  logic                          wr, rd, ok, grp_rst = 1'b0, esd = 1'b0;
  logic [3:0]                    on_push = 4'h0, off_push = 4'h0, port_rst = 4'h0, shut = 4'h0;
  logic [3:0]                    pgood = 4'h0, pd_seen = 4'h0, meas_req, probe_done;
  logic [3:0]                    pwr_valid, pon_fail, pd_det;
  logic [3:0][3:0]               probe_cls, req_cls, asg_cls;
  pac_pkg::pac_class_evt_t [3:0] probe_evt = '0, pon_evt = '0;
  pac_pkg::pac_meas_t [3:0]      meas_res = '0;
  pac_pkg::pac_thresh_t [3:0]    thr;
  logic [6:0]                    pwr_tab [4] = '{7'h20, 7'h01, 7'h33, 7'h7F};
  logic [7:0]                    thr_val = 8'h00;
  int                            eng_cnt [4] = '{default: 0};
  int                            thr_cnt = 0, cycles = 0, err_count = 0, check_count = 0;

  always #10 clk_sys = ~clk_sys;

  pac_top u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .PORT_POWER_ON_PUSH(on_push),
    .PORT_POWER_OFF_PUSH(off_push), .SINGLE_PORT_RESET(port_rst), .PORT_SHUTDOWN_MODE(shut),
    .GROUP_RESET(grp_rst), .EMERGENCY_SHUTDOWN_PIN(esd), .PORT_POWER_GOOD(pgood),
    .PD_REQUEST_SEEN(pd_seen), .PROBE_EVT(probe_evt), .POWER_ON_EVT(pon_evt),
    .MEAS_REQ(meas_req), .MEAS_RESULT(meas_res), .POWER_LIMIT_THRESHOLD(thr),
    .PROBE_CLASS(probe_cls), .REQUESTED_CLASS(req_cls), .ASSIGNED_CLASS(asg_cls),
    .CLASS_PROBE_COMPLETE(probe_done), .PORT_POWER_VALID(pwr_valid),
    .POWER_ON_FAILURE(pon_fail), .PD_REQUEST_DETECTED(pd_det));
  pac_host u_host (.CLK_SYS(clk_sys), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata));

  // --------------------------------
  // Measurement engine and watchers
  // --------------------------------
  // Power lines carry junk outside the valid pulse
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    for (int p = 0; p < 4; p++)
    begin
      meas_res[p] <= {1'b0, ~pwr_tab[p]};
      eng_cnt[p] <= meas_req[p] ? eng_cnt[p] + 1 : 0;
      if (meas_req[p] && eng_cnt[p] == 12)
        meas_res[p] <= {1'b1, pwr_tab[p]};
      if (thr[p].wr === 1'b1)
      begin
        thr_cnt <= thr_cnt + 1;
        thr_val <= thr[p].value;
      end
    end
    if (cycles == 3000)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk(input logic c, input string msg);
    check_count++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic push(input int p);
    @(posedge clk_sys);
    on_push[p] <= 1'b1;
    @(posedge clk_sys);
    on_push[p] <= 1'b0;
    @(negedge clk_sys);
  endtask : push
  task automatic evt(input int p, input logic pon, input logic fl, input logic [3:0] c);
    @(posedge clk_sys);
    if (pon)
      pon_evt[p] <= {1'b1, fl, c};
    else
      probe_evt[p] <= {1'b1, 1'b0, c};
    @(posedge clk_sys);
    pon_evt[p].strobe <= 1'b0;
    probe_evt[p].strobe <= 1'b0;
    @(negedge clk_sys);
  endtask : evt
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_regs;
    u_host.wr(8'h52, 8'hFF);
    for (int a = 8'h50; a <= 8'h55; a++)
    begin
      u_host.rd(a[7:0], rdv);
      chk(rdv === 8'h00, "reset or read-only value");
    end
    $display("test regs done");
  endtask : test_regs
  task automatic test_manual;
    for (int p = 0; p < 4; p++)
    begin
      u_host.wr(8'h50, 8'h10 << p);
      u_host.wr(8'h50, 8'h00);
      u_host.rd(8'h50, rdv);
      chk(rdv === (8'h10 << p), "request dropped by zero write");
      u_host.poll(p, ok);
      chk(ok === 1'b1, "request never cleared");
      u_host.rd(8'h51 + p[7:0], rdv);
      chk(rdv === {1'b0, pwr_tab[p]}, "measured power");
    end
    chk(thr_cnt === 0, "manual run wrote threshold");
    $display("test manual done");
  endtask : test_manual
  task automatic test_auto;
    u_host.wr(8'h50, 8'h01);
    push(0);
    @(posedge clk_sys);
    pd_seen[0] <= 1'b1;
    @(posedge clk_sys);
    pd_seen[0] <= 1'b0;
    evt(0, 1'b1, 1'b0, 4'h4);
    @(posedge clk_sys);
    pgood[0] <= 1'b1;
    for (int i = 0; i < 40 && thr_cnt == 0; i++)
      @(posedge clk_sys);
    @(negedge clk_sys);
    chk(thr_cnt === 1 && thr_val === {1'b0, pwr_tab[0]} + 8'h04, "auto threshold");
    chk(pd_det[0] === 1'b1, "request flag");
    chk(asg_cls[0] === 4'h4 && pwr_valid[0] === 1'b1, "assigned class");
    u_host.wr(8'h50, 8'h00);
    push(1);
    @(posedge clk_sys);
    pgood <= 4'h2;
    repeat (20) @(posedge clk_sys);
    pgood <= 4'h0;
    chk(thr_cnt === 1, "disabled port measured");
    $display("test auto done");
  endtask : test_auto
  task automatic test_class;
    evt(1, 1'b0, 1'b0, 4'h4);
    chk(probe_cls[1] === 4'h4 && probe_done[1] === 1'b1, "probe result");
    push(1);
    chk(req_cls[1] === 4'h4, "requested class");
    evt(1, 1'b1, 1'b1, 4'h7);
    chk(asg_cls[1] === 4'h7 && pon_fail[1] === 1'b1, "failed power-on");
    push(2);
    evt(2, 1'b1, 1'b0, 4'h7);
    chk(asg_cls[2] === 4'h0 && pon_fail[2] === 1'b0, "fail code on success");
    @(posedge clk_sys);
    pd_seen[2] <= 1'b1;
    @(posedge clk_sys);
    pd_seen[2] <= 1'b0;
    @(negedge clk_sys);
    chk(pd_det[2] === 1'b0, "request flag outside window");
    for (int k = 0; k < 5; k++)
    begin
      evt(1, 1'b0, 1'b0, 4'h3);
      push(1);
      evt(1, 1'b1, 1'b0, 4'h3);
      @(posedge clk_sys);
      case (k)
        0: off_push[1] <= 1'b1;
        1: port_rst[1] <= 1'b1;
        2: shut[1] <= 1'b1;
        3: grp_rst <= 1'b1;
        default: esd <= 1'b1;
      endcase
      @(posedge clk_sys);
      off_push <= 4'h0;
      port_rst <= 4'h0;
      grp_rst <= 1'b0;
      repeat (8) @(posedge clk_sys);
      shut <= 4'h0;
      esd <= 1'b0;
      @(negedge clk_sys);
      chk(probe_cls[1] === 4'h0 && req_cls[1] === 4'h0 && asg_cls[1] === 4'h0, "clear");
    end
    $display("test class done");
  endtask : test_class

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_regs();
    test_manual();
    test_auto();
    test_class();
    print_verdict();
  end
endmodule : pac_top_tb_top

bind pac_top pac_top_monitor u_mon (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .PORT_POWER_ON_PUSH(PORT_POWER_ON_PUSH), .PORT_POWER_OFF_PUSH(PORT_POWER_OFF_PUSH),
  .SINGLE_PORT_RESET(SINGLE_PORT_RESET), .PORT_SHUTDOWN_MODE(PORT_SHUTDOWN_MODE),
  .GROUP_RESET(GROUP_RESET), .PROBE_EVT(PROBE_EVT), .POWER_ON_EVT(POWER_ON_EVT),
  .MEAS_REQ(MEAS_REQ), .MEAS_RESULT(MEAS_RESULT), .POWER_LIMIT_THRESHOLD(POWER_LIMIT_THRESHOLD),
  .PROBE_CLASS(PROBE_CLASS), .REQUESTED_CLASS(REQUESTED_CLASS), .ASSIGNED_CLASS(ASSIGNED_CLASS),
  .CLASS_PROBE_COMPLETE(CLASS_PROBE_COMPLETE), .POWER_ON_FAILURE(POWER_ON_FAILURE));
